// File: dcp_chan_cond.sv
// Channel conditioning top: modulator sample decimation with per-channel
// phase offset, input test selection, DC removal and data-ready output.
// Assumes modulator samples arrive on the same clock, one per channel,
// valid at every modulator-rate tick made by the internal divider.
//
// Function
// - Nonzero shared cutoff code enables DC removal; zero bypasses it.
// - Each channel has a disable bit bypassing DC removal individually.
// - Coefficient halves per code step: code 1 is 1/4, 15 is 1/65536.
// - DC removal runs at output sample rate, response scales with rate.
// - Two-bit select routes normal input or positive/negative test level.
// - Phase field is 10-bit two's complement count of modulator cycles.
// - Each result uses exactly OSR samples; zero phases align windows.
// - Nonzero phase shifts that channel's window by that many cycles.
// - Usable phase is -OSR/2 to OSR/2-1, at most -512 to 511.
// - Out-of-range phase saturates to the nearest limit, never wraps.
// - Data-ready timing follows the programmed channel phases.
//
// Local design decisions: the address map and the address-and-strobe port.
module dcp_chan_cond
	import dcp_pkg::*;
#(
	parameter int NCH = NCH_DEF,
	parameter int MOD_DIV = MOD_DIV_DEF
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Modulator samples, channel n in lane n
	input wire logic [NCH*MOD_W-1:0] mod_sample,
	// Modulator rate tick and data ready
	output logic modulator_rate,
	output logic sample_available_n
);

	localparam logic [DIV_CW-1:0] DIV_LAST = DIV_CW'(MOD_DIV - 1);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [CODE_W-1:0] dc_removal_cutoff_code;
	logic [SEL_W-1:0] osr_sel;
	logic [CFG_W-1:0] channel_config [NCH];
	logic signed [RES_W-1:0] chan_data [NCH];
	logic signed [PH_W-1:0] phase_clip [NCH];
	logic [CNT_W-1:0] end_pos [NCH];
	logic signed [MOD_W-1:0] smp [NCH];
	logic signed [SUM_W-1:0] acc [NCH];
	logic signed [SUM_W-1:0] win_sum [NCH];
	logic signed [RES_W-1:0] win_res [NCH];
	logic signed [RES_W-1:0] hpf_data [NCH];
	logic [NCH-1:0] new_flag;
	logic [NCH-1:0] next_new;
	logic [NCH-1:0] primed;
	logic [NCH-1:0] win_end;
	logic [NCH-1:0] hpf_valid;
	logic [NCH-1:0] data_rd;
	logic [NCH-1:0] cfg_wr;
	logic [DIV_CW-1:0] div_cnt;
	logic [CNT_W-1:0] mod_cnt;
	logic [CNT_W-1:0] osr_last;
	logic [DATA_W-1:0] rd_value;
	logic mod_tick;
	logic osr_wr;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Oversampling ratio from its select, 128 up to 16384
	function automatic logic [CNT_W-1:0] osr_of(input logic [SEL_W-1:0] sel);
		return OSR_BASE << sel;
	endfunction : osr_of

	// Half of the usable phase span for a select
	function automatic logic signed [PH_W:0] phase_half(
		input logic [SEL_W-1:0] sel
	);
		if (sel >= PH_FULL_SEL)
			return PH_HALF_MAX;
		return PH_HALF_BASE << sel;
	endfunction : phase_half

	// Saturate a programmed phase into the usable span
	function automatic logic signed [PH_W-1:0] clip_phase(
		input logic [PH_W-1:0] raw,
		input logic [SEL_W-1:0] sel
	);
		logic signed [PH_W:0] v;
		logic signed [PH_W:0] half;
		v = {raw[PH_W-1], raw};
		half = phase_half(sel);
		if (v > half - 11'sd1)
			v = half - 11'sd1;
		else if (v < -half)
			v = -half;
		return v[PH_W-1:0];
	endfunction : clip_phase

	// Register word hit for channel index i of a block starting at base
	function automatic logic idx_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] base,
		input int i
	);
		return addr == base + ADDR_W'(i) * OFF_STRIDE;
	endfunction : idx_hit

	// Scale a window sum to full result width whatever the ratio
	function automatic logic signed [RES_W-1:0] normalize(
		input logic signed [SUM_W-1:0] s,
		input logic [SEL_W-1:0] sel
	);
		logic signed [RES_W-1:0] w;
		w = RES_W'(s);
		return w <<< (OSR_SEL_MAX - sel);
	endfunction : normalize

	// ------------------------------------------------------------------
	// Modulator rate divider and window position
	// ------------------------------------------------------------------
	// One enable pulse per modulator cycle, no second clock
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			div_cnt <= '0;
		else if (div_cnt == DIV_LAST)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + DIV_CW'(1);
	end

	assign mod_tick = (div_cnt == DIV_LAST);
	assign modulator_rate = mod_tick;
	assign osr_last = osr_of(osr_sel) - CNT_W'(1);

	// Common reference position; a ratio change restarts it so all
	// channels realign from the same zero
	always_ff @(posedge clock)
	begin
		if (sys_rst || osr_wr)
			mod_cnt <= '0;
		else if (mod_tick)
			mod_cnt <= (mod_cnt >= osr_last) ? '0 : mod_cnt + CNT_W'(1);
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	assign osr_wr = reg_wr && (reg_addr == OFF_OSR);

	// Control registers written by software
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			dc_removal_cutoff_code <= CODE_RST;
			osr_sel <= OSR_SEL_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == OFF_CUTOFF)
				dc_removal_cutoff_code <= reg_wdata[CODE_W-1:0];
			if (osr_wr)
				osr_sel <= reg_wdata[SEL_W-1:0];
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_value = '0;
		if (reg_addr == OFF_CUTOFF)
			rd_value[CODE_W-1:0] = dc_removal_cutoff_code;
		if (reg_addr == OFF_OSR)
			rd_value[SEL_W-1:0] = osr_sel;
		if (reg_addr == OFF_STATUS)
			rd_value[2*NCH-1:0] = {primed, new_flag};
		for (int i = 0; i < NCH; i++)
		begin
			if (idx_hit(reg_addr, OFF_CFG0, i))
				rd_value[CFG_W-1:0] = channel_config[i];
			if (idx_hit(reg_addr, OFF_DATA0, i))
				rd_value[RES_W-1:0] = chan_data[i];
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_value : '0;
	end

	// ------------------------------------------------------------------
	// Per-channel datapath
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gen_ch
			logic [1:0] in_sel;
			logic [CNT_W-1:0] win_ticks;

			assign cfg_wr[g] = reg_wr && idx_hit(reg_addr, OFF_CFG0, g);
			assign data_rd[g] = reg_rd && idx_hit(reg_addr, OFF_DATA0, g);
			assign in_sel = channel_config[g][CFG_SEL_LSB +: 2];

			// Channel configuration word
			always_ff @(posedge clock)
			begin
				if (sys_rst)
					channel_config[g] <= '0;
				else if (cfg_wr[g])
					channel_config[g] <= reg_wdata[CFG_W-1:0];
			end

			// Input select; code 3 is treated as the normal input
			always_comb
			begin
				case (in_sel)
					SEL_TEST_POS: smp[g] = TEST_LEVEL;
					SEL_TEST_NEG: smp[g] = -TEST_LEVEL;
					default: smp[g] = mod_sample[g*MOD_W +: MOD_W];
				endcase
			end

			// Window end sits at the clipped phase, modulo the ratio
			assign phase_clip[g] = clip_phase(channel_config[g][CFG_PH_LSB +: PH_W],
				osr_sel);
			assign end_pos[g] = {{(CNT_W-PH_W){phase_clip[g][PH_W-1]}},
				phase_clip[g]} & osr_last;
			assign win_end[g] = mod_tick && (mod_cnt == end_pos[g]);
			assign win_sum[g] = acc[g] + SUM_W'(smp[g]);
			assign win_res[g] = normalize(win_sum[g], osr_sel);

			// Boxcar accumulator over one window of OSR samples
			always_ff @(posedge clock)
			begin
				if (sys_rst || win_end[g])
					acc[g] <= '0;
				else if (mod_tick)
					acc[g] <= win_sum[g];
			end

			// A window cut short by a settings change is dropped
			always_ff @(posedge clock)
			begin
				if (sys_rst || osr_wr || cfg_wr[g])
					primed[g] <= 1'b0;
				else if (win_end[g])
					primed[g] <= 1'b1;
			end

			dcp_dc_removal u_dc (
				.clock(clock),
				.sys_rst(sys_rst),
				.in_valid(win_end[g] && primed[g]),
				.in_data(win_res[g]),
				.cutoff_code(dc_removal_cutoff_code),
				.chan_disable(channel_config[g][CFG_DIS_BIT]),
				.out_valid(hpf_valid[g]),
				.out_data(hpf_data[g])
			);

			// Result holding register read by software
			always_ff @(posedge clock)
			begin
				if (sys_rst)
					chan_data[g] <= '0;
				else if (hpf_valid[g])
					chan_data[g] <= hpf_data[g];
			end

			// New result beats a read in the same cycle
			assign next_new[g] = hpf_valid[g] || (new_flag[g] && !data_rd[g]);

			// Helper: modulator ticks seen in the current window
			always_ff @(posedge clock)
			begin
				if (sys_rst || win_end[g])
					win_ticks <= '0;
				else if (mod_tick)
					win_ticks <= win_ticks + CNT_W'(1);
			end

			AST_WINDOW_LEN: assert property (@(posedge clock) disable iff (sys_rst)
				win_end[g] && primed[g] |-> win_ticks == osr_last)
				else $error("window did not hold exactly OSR samples");

			AST_PHASE_RANGE: assert property (@(posedge clock) disable iff (sys_rst)
				phase_clip[g] >= -phase_half(osr_sel) &&
				phase_clip[g] < phase_half(osr_sel))
				else $error("clipped phase outside usable span");

			AST_PHASE_SAT_HI: assert property (@(posedge clock) disable iff (sys_rst)
				$signed({channel_config[g][PH_W-1], channel_config[g][PH_W-1:0]})
				>= phase_half(osr_sel) |->
				{phase_clip[g][PH_W-1], phase_clip[g]} == phase_half(osr_sel) - 11'sd1)
				else $error("high phase not saturated to upper limit");

			AST_SHIFT_POS: assert property (@(posedge clock) disable iff (sys_rst)
				mod_tick && mod_cnt == (CNT_W'($signed(phase_clip[g])) & osr_last)
				|-> win_end[g])
				else $error("window end not at programmed phase");

			AST_TEST_MUX: assert property (@(posedge clock) disable iff (sys_rst)
				in_sel == SEL_TEST_NEG |-> smp[g] == -TEST_LEVEL)
				else $error("negative test level not selected");

			COV_CLIPPED: cover property (@(posedge clock) disable iff (sys_rst)
				win_end[g] && phase_clip[g] != channel_config[g][PH_W-1:0]);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Data ready
	// ------------------------------------------------------------------
	// Low once every channel holds an unread result, so the latest phase
	// sets the moment; it stays low until software reads a result
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			new_flag <= '0;
			sample_available_n <= 1'b1;
		end
		else
		begin
			new_flag <= next_new;
			sample_available_n <= !(&next_new);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	AST_ZERO_ALIGN: assert property (@(posedge clock) disable iff (sys_rst)
		mod_tick && mod_cnt == '0 && phase_clip[0] == '0 |-> win_end[0])
		else $error("zero phase window not aligned to reference");

	AST_READY_CAUSE: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(sample_available_n) |-> $past(|hpf_valid))
		else $error("data ready fell without a new result");

	AST_READY_NEXT: assert property (@(posedge clock) disable iff (sys_rst)
		(&(hpf_valid | new_flag)) && !(|data_rd) |=> !sample_available_n)
		else $error("data ready did not fall after all channels had results");

	COV_READY: cover property (@(posedge clock) disable iff (sys_rst)
		$fell(sample_available_n));

	COV_TEST_POS: cover property (@(posedge clock) disable iff (sys_rst)
		win_end[0] && primed[0] && gen_ch[0].in_sel == SEL_TEST_POS);

	COV_READ_CLEAR: cover property (@(posedge clock) disable iff (sys_rst)
		!sample_available_n ##1 reg_rd && |data_rd ##1 sample_available_n);

endmodule : dcp_chan_cond

// File: dcp_dc_removal.sv
// First-order recursive DC removal stage for one channel.
// Assumes one in_valid pulse per output-rate sample from the decimator.
module dcp_dc_removal
	import dcp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Sample in
	input wire logic in_valid,
	input wire logic signed [RES_W-1:0] in_data,
	// Settings
	input wire logic [CODE_W-1:0] cutoff_code,
	input wire logic chan_disable,
	// Sample out
	output logic out_valid,
	output logic signed [RES_W-1:0] out_data
);

	localparam int ST_W = RES_W + FRAC_W + 1;
	localparam logic signed [ST_W-1:0] Y_MAX = ST_W'((1 <<< (RES_W - 1)) - 1);
	localparam logic signed [ST_W-1:0] Y_MIN = -Y_MAX - ST_W'(1);

	logic signed [ST_W-1:0] state;
	logic signed [ST_W-1:0] x_ext;
	logic signed [ST_W-1:0] diff;
	logic signed [ST_W-1:0] y_full;
	logic [CODE_W:0] shift;
	logic bypass;

	// Limit to the output width; the step response can overshoot it
	function automatic logic signed [RES_W-1:0] sat(
		input logic signed [ST_W-1:0] v
	);
		if (v > Y_MAX)
			return Y_MAX[RES_W-1:0];
		else if (v < Y_MIN)
			return Y_MIN[RES_W-1:0];
		return v[RES_W-1:0];
	endfunction : sat

	// Filter arithmetic, state keeps FRAC_W fraction bits
	assign bypass = (cutoff_code == CODE_OFF) || chan_disable;
	assign x_ext = ST_W'(in_data) <<< FRAC_W;
	assign diff = x_ext - state;
	assign y_full = diff >>> FRAC_W;
	assign shift = {1'b0, cutoff_code} + 5'h01;

	// Running mean, moved only on a sample; cleared in bypass so that
	// re-enabling starts from rest instead of a stale estimate
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			state <= '0;
		else if (in_valid)
		begin
			if (bypass)
				state <= '0;
			else
				state <= state + (diff >>> shift);
		end
	end

	// Registered output stage
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else
		begin
			out_valid <= in_valid;
			if (in_valid)
				out_data <= bypass ? in_data : sat(y_full);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	AST_BYPASS_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
		in_valid && cutoff_code == CODE_OFF |=> out_valid && out_data == $past(in_data))
		else $error("zero cutoff code did not pass the sample unchanged");

	AST_DISABLE_PASS: assert property (@(posedge clock) disable iff (sys_rst)
		in_valid && chan_disable |=> out_data == $past(in_data) && state == '0)
		else $error("disabled channel was filtered");

	AST_COEF_STEP: assert property (@(posedge clock) disable iff (sys_rst)
		in_valid && !bypass && state == '0 |=>
		state == ($past(x_ext) >>> ({1'b0, $past(cutoff_code)} + 5'h01)))
		else $error("first state step does not match the power of two coefficient");

	AST_RATE_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
		!in_valid |=> $stable(state) && !out_valid)
		else $error("filter moved between output samples");

	AST_FROM_REST: assert property (@(posedge clock) disable iff (sys_rst)
		in_valid && !bypass && state == '0 |=> out_data == $past(in_data))
		else $error("filter from rest did not pass the first sample");

	COV_FILTERING: cover property (@(posedge clock) disable iff (sys_rst)
		in_valid && !bypass && state != '0);

endmodule : dcp_dc_removal

// File: dcp_mod_source.sv
// Modulator sample source standing in for the converter front end.
// Assumes modulator_rate comes from the block on the same clock.
module dcp_mod_source
	import dcp_pkg::*;
#(
	parameter int NCH = NCH_DEF
)
(
	// Tick from the block
	input wire logic modulator_rate,
	// Per-channel constant level from the bench
	input wire logic [NCH*MOD_W-1:0] level,
	// Samples to the block
	output logic [NCH*MOD_W-1:0] mod_sample
);
	timeunit 1ns;
	timeprecision 1ps;

	// Off-tick cycles carry the inverted level, so a block that samples
	// outside its tick picks up a wrong sum
	assign mod_sample = modulator_rate ? level : ~level;
endmodule : dcp_mod_source

// File: dcp_pkg.sv
// Shared constants for the channel conditioning block: register map,
// field layout, reset values and datapath widths.
// Assumes it is compiled before every other file of the block.
package dcp_pkg;

	// ------------------------------------------------------------------
	// Datapath widths
	// ------------------------------------------------------------------
	localparam int NCH_DEF = 4;
	localparam int MOD_W = 8;
	localparam int RES_W = 24;
	localparam int SUM_W = 23;
	localparam int PH_W = 10;
	localparam int CODE_W = 4;
	localparam int SEL_W = 3;
	localparam int CNT_W = 15;
	localparam int FRAC_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DIV_CW = 16;
	localparam int MOD_DIV_DEF = 2;

	// ------------------------------------------------------------------
	// Oversampling and phase limits
	// ------------------------------------------------------------------
	localparam logic [CNT_W-1:0] OSR_BASE = 15'h0080;
	localparam logic [SEL_W-1:0] OSR_SEL_MAX = 3'h7;
	localparam logic [SEL_W-1:0] OSR_SEL_RST = 3'h3;
	localparam logic [SEL_W-1:0] PH_FULL_SEL = 3'h3;
	localparam logic [PH_W:0] PH_HALF_BASE = 11'h040;
	localparam logic [PH_W:0] PH_HALF_MAX = 11'h200;

	// ------------------------------------------------------------------
	// Channel configuration layout
	// ------------------------------------------------------------------
	localparam int CFG_W = 13;
	localparam int CFG_PH_LSB = 0;
	localparam int CFG_DIS_BIT = 10;
	localparam int CFG_SEL_LSB = 11;
	localparam logic [1:0] SEL_NORMAL = 2'h0;
	localparam logic [1:0] SEL_TEST_POS = 2'h1;
	localparam logic [1:0] SEL_TEST_NEG = 2'h2;
	localparam logic signed [MOD_W-1:0] TEST_LEVEL = 8'sh11;
	localparam logic [CODE_W-1:0] CODE_OFF = 4'h0;
	localparam logic [CODE_W-1:0] CODE_RST = 4'h0;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CUTOFF = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_OSR = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CFG0 = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_DATA0 = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_STRIDE = 8'h04;

endpackage : dcp_pkg

// File: testbench.sv
// Self-checking bench for the channel conditioning block.
// Assumes dcp_pkg, the block and the sample source are compiled first.
module testbench
	import dcp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	// Window sum of 128<<sel samples shifted by 7-sel is always x * 2^14
	localparam int RES_SHIFT = 14;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [NCH_DEF*MOD_W-1:0] level = '0;
	logic [NCH_DEF*MOD_W-1:0] mod_sample;
	logic modulator_rate;
	logic sample_available_n;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 32'h09559501;
	logic [PH_W-1:0] ph [NCH_DEF];
	logic [1:0] isel [NCH_DEF];
	logic dis [NCH_DEF];
	logic [DATA_W-1:0] res [NCH_DEF];
	logic [PH_W-1:0] corner [2][NCH_DEF] = '{'{10'h064, 10'h39C, 10'h1FF,
		10'h200}, '{10'h03F, 10'h3C0, 10'h000, 10'h000}};

	always #10 clock = ~clock;

	dcp_chan_cond #(.NCH(NCH_DEF), .MOD_DIV(2)) i_dut (.clock(clock),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mod_sample(mod_sample), .modulator_rate(modulator_rate),
		.sample_available_n(sample_available_n));

	dcp_mod_source #(.NCH(NCH_DEF)) i_src (.modulator_rate(modulator_rate),
		.level(level), .mod_sample(mod_sample));

	// ------------------------------------------------------------------
	// Tasks and expectations
	// ------------------------------------------------------------------
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [DATA_W-1:0] got,
		input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One-cycle strobes; a gap edge between calls keeps drives apart
	task automatic reg_write(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read

	task automatic read_all;
		for (int n = 0; n < NCH_DEF; n++)
			reg_read(OFF_DATA0 + ADDR_W'(4 * n), res[n]);
	endtask : read_all

	// Counts ticks until data ready falls; bounded so a hang cannot stall
	task automatic wait_fall(output int ticks);
		ticks = 0;
		do
		begin
			@(negedge clock);
			if (modulator_rate)
				ticks++;
		end
		while (sample_available_n !== 1'b0 && ticks < 40000);
	endtask : wait_fall

	// Program channels, restart the reference count, then time the result
	task automatic measure(input int sel, output int ticks);
		logic [DATA_W-1:0] st;
		for (int n = 0; n < NCH_DEF; n++)
			reg_write(OFF_CFG0 + ADDR_W'(4 * n),
				DATA_W'({isel[n], dis[n], ph[n]}));
		reg_write(OFF_OSR, DATA_W'(sel));
		read_all();
		wait_fall(ticks);
		// Every channel holds a fresh result from a full window
		reg_read(OFF_STATUS, st);
		check(st, DATA_W'((1 << (2 * NCH_DEF)) - 1));
		read_all();
		check(DATA_W'(sample_available_n), 32'h00000001);
	endtask : measure

	function automatic logic [DATA_W-1:0] exp_res(input int n);
		logic signed [RES_W-1:0] x;
		x = RES_W'($signed(level[n*MOD_W +: MOD_W]));
		if (isel[n] == SEL_TEST_POS)
			x = RES_W'(TEST_LEVEL);
		if (isel[n] == SEL_TEST_NEG)
			x = -RES_W'(TEST_LEVEL);
		return {8'h00, x <<< RES_SHIFT};
	endfunction : exp_res

	// Clipped phase expressed as a window-end delay in ticks
	function automatic int clip_mod(input logic [PH_W-1:0] raw, input int sel);
		int osr;
		int half;
		int v;
		osr = int'(OSR_BASE) << sel;
		half = (osr / 2 > int'(PH_HALF_MAX)) ? int'(PH_HALF_MAX) : osr / 2;
		v = int'($signed(raw));
		if (v > half - 1)
			v = half - 1;
		if (v < -half)
			v = -half;
		return (v + osr) % osr;
	endfunction : clip_mod

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 50000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		int base;
		int t;
		int e;
		logic [DATA_W-1:0] d;
		logic signed [RES_W-1:0] y;
		logic [DATA_W-1:0] prev [NCH_DEF];
		for (int n = 0; n < NCH_DEF; n++)
			level[n*MOD_W +: MOD_W] = MOD_W'($random(seed));
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		// Tick alternates each clock at the divide-by-two setting
		@(negedge clock);
		d = DATA_W'(modulator_rate);
		@(negedge clock);
		check(DATA_W'(modulator_rate), d ^ 32'h00000001);
		// Reset values, field masks, read-only and unmapped places
		reg_read(OFF_OSR, d);
		check(d, DATA_W'(OSR_SEL_RST));
		reg_write(OFF_CUTOFF, 32'hFFFFFFFF);
		reg_read(OFF_CUTOFF, d);
		check(d, 32'h0000000F);
		reg_write(OFF_CFG0, 32'hFFFFFFFF);
		reg_read(OFF_CFG0, d);
		check(d, 32'h00001FFF);
		reg_write(OFF_DATA0, 32'h00123456);
		reg_write(8'h3C, 32'hFFFFFFFF);
		reg_read(OFF_DATA0, d);
		check(d, 32'h00000000);
		reg_read(8'h3C, d);
		check(d, 32'h00000000);
		reg_write(OFF_CUTOFF, 32'h00000000);
		// Phase shift, clipping and data-ready timing at OSR 128 and 256
		for (int s = 0; s < 2; s++)
		begin
			for (int n = 0; n < NCH_DEF; n++)
			begin
				ph[n] = '0;
				dis[n] = 1'b0;
				isel[n] = 2'($random(seed));
			end
			measure(s, base);
			for (int k = 0; k < 5; k++)
			begin
				e = 0;
				for (int n = 0; n < NCH_DEF; n++)
				begin
					// Corners sit at or past the OSR 128 limits, or at zero; random draws stay inside
					// one sample, whole samples being realigned by the host
					ph[n] = (k < 2) ? corner[k][n] :
						PH_W'($random(seed) % (int'(PH_HALF_BASE) << s));
					isel[n] = 2'($random(seed));
					if (clip_mod(ph[n], s) > e)
						e = clip_mod(ph[n], s);
				end
				measure(s, t);
				check(DATA_W'(t - base), DATA_W'(e));
				for (int n = 0; n < NCH_DEF; n++)
					check(res[n], exp_res(n));
			end
		end
		// DC removal: consecutive outputs follow y' = y - y/2^(code+1)
		for (int c = 1; c < 4; c += 2)
		begin
			reg_write(OFF_CUTOFF, DATA_W'(c));
			for (int n = 0; n < NCH_DEF; n++)
			begin
				ph[n] = '0;
				dis[n] = (n == 1);
				isel[n] = (n == 2) ? SEL_TEST_NEG : SEL_NORMAL;
			end
			measure(0, t);
			prev = res;
			wait_fall(t);
			read_all();
			for (int n = 0; n < NCH_DEF; n++)
			begin
				// Filter starts from rest, so its first output is the input
				if (c == 1)
					check(prev[n], exp_res(n));
				y = prev[n][RES_W-1:0];
				y = y - (y >>> (c + 1));
				if (dis[n])
					check(res[n], exp_res(n));
				else
					check(res[n], {8'h00, y});
			end
		end
		tally_and_finish();
	end
endmodule : testbench
